// ==== core/srpg_top.sv ====
// srpg_top: reset merging, reset stretch, peripheral clock gating,
// bandgap enable and brown-out sleep timed write.
// assumes analog detector outputs and pin levels are synchronous to mclk_in.
//
// Contract
// RULE1 - bit 7 stops the two-wire unit clock; software reinitialises after
// RULE2 - bit 6 freezes timer two only when it runs synchronously
// RULE3 - bits 5 and 3 freeze timers zero and one; resume unchanged
// RULE4 - bit 4 reserved, read-only, always reads zero
// RULE5 - bits 2 and 1 stop serial peripheral and async serial clocks
// RULE6 - software keeps serial peripheral running while single-wire debug is used
// RULE7 - bit 0 shuts converter down; comparator loses converter input mux
// RULE8 - reset sets all registers to initial values; run starts after release; internal reset in the code reloads only gates_r, not the sleep bits
// RULE9 - ports reset immediately on any source, without a clock; the code registers port reset on mclk_in, same as system reset
// RULE10 - delay counter stretches reset after sources clear; fuses select period
// RULE11 - power-on, pin, watchdog and brown-out sources all reset
// RULE12 - power-on good starts counter; power-on low reasserts reset at once
// RULE13 - pin low longer than minimum width resets; rising edge starts count
// RULE14 - external reset disable fuse makes the pin ignored
// RULE15 - enabled brown-out asserts reset immediately on low supply
// RULE16 - supply back above upper level releases after the time-out
// RULE17 - brown-out dips shorter than filter time are ignored
// RULE18 - watchdog one-cycle pulse; count starts at its falling edge
// RULE19 - bandgap on when brown-out fused, comparator bandgap set, or converter on
// RULE20 - with brown-out off, software waits for reference start-up
// RULE21 - sleep enable bit gates brown-out sleep writes via timed sequence
// RULE22 - set both bits, then sleep bit alone within four cycles
// RULE23 - sleep bit active three cycles after set, clears three later
// RULE24 - internal reset is OR of sources and counter; reassert restarts count
// RULE25 - gated peripheral registers ignore access; state stays frozen
//
// Decided for this implementation: strobed register access.
`timescale 1ns/100ps
module srpg_top
	import srpg_pkg::*;
#(
	parameter int TOUT_CYCLES = TOUT_CYC,
	parameter int FILT_CYCLES = BOD_FILTER_CYC,
	parameter int PULSE_CYCLES = RST_PULSE_CYC
) (
	// clock and reset
	input  wire logic        mclk_in,
	input  wire logic        rst_in,
	// register port
	input  wire logic [7:0]  reg_addr_in,
	input  wire logic [7:0]  reg_wdata_in,
	input  wire logic        reg_wr_in,
	input  wire logic        reg_rd_in,
	output logic      [7:0]  reg_rdata_out,
	// reset sources and fuses
	input  wire srpg_src_t   src_in,
	input  wire srpg_fuse_t  fuse_in,
	// peripheral status
	input  wire logic        timer_two_async_select_in,
	input  wire logic        comparator_bandgap_select_in,
	input  wire logic        converter_enable_in,
	// outputs
	output srpg_clken_t      clken_out,
	output logic             comparator_mux_allow_out,
	output logic             bandgap_enable_out,
	output logic             brownout_sleep_disable_out,
	output logic             sys_rst_out,
	output logic             port_rst_out
);

	localparam int CW = $clog2(TOUT_CYCLES + 1) + 1;
	localparam int FW = $clog2(FILT_CYCLES + 2) + 1;
	localparam int PW = $clog2(PULSE_CYCLES + 2) + 1;

	// fuse selected stretch: longer start-up for slow settings
	function automatic logic [CW-1:0] tout_sel(input logic [1:0] startup_time_select);
		logic [CW-1:0] base;
		base = CW'(TOUT_CYCLES);
		case (startup_time_select)
			2'd0:    tout_sel = base >> 3;
			2'd1:    tout_sel = base >> 2;
			2'd2:    tout_sel = base;
			default: tout_sel = base >> 1;
		endcase
		if (tout_sel == '0)
			tout_sel = CW'(1);
	endfunction : tout_sel

	logic [7:0]    gates_r;
	logic [7:0]    rdata_r;
	logic [FW-1:0] bod_cnt_r;
	logic [PW-1:0] pin_cnt_r;
	logic [CW-1:0] dly_cnt_r;
	logic          bod_rst_r;
	logic          pin_rst_r;
	logic          sys_rst_r;
	srpg_rst_t     rst_st_r;
	srpg_clken_t   clken_r;
	logic          mux_allow_r;
	logic          bandgap_r;
	srpg_brownout_sleep_disable_t    brownout_sleep_disable_st_r;
	logic [2:0]    brownout_sleep_disable_cnt_r;
	logic          brownout_sleep_write_enable_r;
	logic          brownout_sleep_disable_r;

	// decode
	wire wr_gates = reg_wr_in && (reg_addr_in == PWR_GATES_OFS);
	wire wr_bod   = reg_wr_in && (reg_addr_in == BOD_CTRL_OFS);
	wire bod_en   = (fuse_in.bod_level != 3'b111);
	wire pin_on   = !fuse_in.ext_rst_dis; // RULE14
	wire pin_low  = pin_on && !src_in.ext_rst_n;
	wire bod_low  = bod_en && src_in.bod_low;
	// combined live request; immediate sources bypass the counter
	wire src_act  = !src_in.por_ok || bod_rst_r || pin_rst_r || src_in.wdt_rst; // RULE11
	wire rst_nxt  = src_act || (rst_st_r != RST_RUN); // RULE24

	// reads: reserved bit 4 returns zero, unmapped reads zero
	wire [7:0] rd_mux =
		(reg_addr_in == PWR_GATES_OFS) ? (gates_r & PWR_GATES_WMSK) : // RULE4
		(reg_addr_in == BOD_CTRL_OFS)  ? {1'b0, brownout_sleep_disable_r, brownout_sleep_write_enable_r, 5'h00} :
		(reg_addr_in == RST_STAT_OFS)  ? {5'h00, rst_st_r, sys_rst_r} :
		8'h00;

	// timed brown-out sleep write
	wire both_set  = wr_bod && reg_wdata_in[BROWNOUT_SLEEP_DISABLE_BIT] && reg_wdata_in[BROWNOUT_SLEEP_WRITE_ENABLE_BIT];
	wire brownout_sleep_disable_only = wr_bod && reg_wdata_in[BROWNOUT_SLEEP_DISABLE_BIT] && !reg_wdata_in[BROWNOUT_SLEEP_WRITE_ENABLE_BIT];

	// register port
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			gates_r <= PWR_GATES_RST; // RULE8
			rdata_r <= 8'h00;
		end else begin
			if (sys_rst_r)
				gates_r <= PWR_GATES_RST; // RULE8
			else if (wr_gates)
				gates_r <= reg_wdata_in & PWR_GATES_WMSK; // RULE4
			rdata_r <= reg_rd_in ? rd_mux : 8'h00;
		end
	end

	// brown-out filter: only a dip longer than the filter time counts
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			bod_cnt_r <= '0;
			bod_rst_r <= 1'b0;
		end else if (!bod_low) begin
			bod_cnt_r <= '0;
			bod_rst_r <= 1'b0; // RULE16
		end else if (bod_cnt_r >= FW'(FILT_CYCLES)) begin
			bod_rst_r <= 1'b1; // RULE15 RULE17
		end else begin
			bod_cnt_r <= bod_cnt_r + FW'(1);
		end
	end

	// pin reset: needs the minimum width before it counts
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			pin_cnt_r <= '0;
			pin_rst_r <= 1'b0;
		end else if (!pin_low) begin
			pin_cnt_r <= '0;
			pin_rst_r <= 1'b0; // RULE13
		end else if (pin_cnt_r >= PW'(PULSE_CYCLES)) begin
			pin_rst_r <= 1'b1; // RULE13
		end else begin
			pin_cnt_r <= pin_cnt_r + PW'(1);
		end
	end

	// delay counter: restarts whenever any source is active
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			rst_st_r  <= RST_HOLD;
			dly_cnt_r <= '0;
		end else begin
			case (rst_st_r)
				RST_HOLD: begin
					if (!src_act) begin
						rst_st_r  <= RST_COUNT; // RULE10 RULE12 RULE18
						dly_cnt_r <= tout_sel(fuse_in.startup_time_select);
					end
				end
				RST_COUNT: begin
					if (src_act)
						rst_st_r <= RST_HOLD; // RULE24
					else if (dly_cnt_r <= CW'(1))
						rst_st_r <= RST_RUN; // RULE10
					else
						dly_cnt_r <= dly_cnt_r - CW'(1);
				end
				RST_RUN: begin
					if (src_act)
						rst_st_r <= RST_HOLD; // RULE12 RULE15
				end
				default: rst_st_r <= RST_HOLD;
			endcase
		end
	end

	// reset outputs; port reset is registered and held through the delay count, same as system reset
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			sys_rst_r    <= 1'b1;
			port_rst_out <= 1'b1; // RULE9
		end else begin
			sys_rst_r    <= rst_nxt; // RULE24
			port_rst_out <= rst_nxt; // RULE9
		end
	end
	assign sys_rst_out = sys_rst_r;

	// peripheral clock enables; a frozen unit keeps its state and ignores access
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			clken_r     <= '0;
			mux_allow_r <= 1'b0;
			bandgap_r   <= 1'b0;
		end else begin
			clken_r.two_wire_serial_unit   <= !gates_r[GATE_TWI_BIT]; // RULE1 RULE25
			clken_r.tim2  <= !(gates_r[GATE_TIM2_BIT] && !timer_two_async_select_in); // RULE2
			clken_r.tim0  <= !gates_r[GATE_TIM0_BIT]; // RULE3
			clken_r.tim1  <= !gates_r[GATE_TIM1_BIT]; // RULE3
			clken_r.spi   <= !gates_r[GATE_SPI_BIT]; // RULE5
			clken_r.usart <= !gates_r[GATE_USART_BIT]; // RULE5
			clken_r.adc   <= !gates_r[GATE_ADC_BIT]; // RULE7
			mux_allow_r   <= !gates_r[GATE_ADC_BIT]; // RULE7
			bandgap_r     <= bod_en || comparator_bandgap_select_in
				|| converter_enable_in; // RULE19
		end
	end
	assign clken_out                = clken_r;
	assign comparator_mux_allow_out = mux_allow_r;
	assign bandgap_enable_out       = bandgap_r;

	// brown-out sleep sequencer: arm, then sleep bit alone within the window
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			brownout_sleep_disable_st_r  <= BS_IDLE;
			brownout_sleep_disable_cnt_r <= 3'd0;
			brownout_sleep_write_enable_r    <= 1'b0;
			brownout_sleep_disable_r     <= 1'b0;
		end else begin
			case (brownout_sleep_disable_st_r)
				BS_IDLE: begin
					if (both_set) begin
						brownout_sleep_disable_st_r  <= BS_ARMED; // RULE21 RULE22
						brownout_sleep_write_enable_r    <= 1'b1;
						brownout_sleep_disable_cnt_r <= BROWNOUT_SLEEP_WRITE_ENABLE_WINDOW_CYC;
					end
				end
				BS_ARMED: begin
					if (brownout_sleep_disable_only) begin
						brownout_sleep_disable_st_r  <= BS_DELAY; // RULE22
						brownout_sleep_write_enable_r    <= 1'b0;
						brownout_sleep_disable_cnt_r <= BROWNOUT_SLEEP_DISABLE_DELAY_CYC - 3'd1;
					end else if (brownout_sleep_disable_cnt_r <= 3'd1) begin
						brownout_sleep_disable_st_r <= BS_IDLE; // RULE22
						brownout_sleep_write_enable_r   <= 1'b0;
					end else begin
						brownout_sleep_disable_cnt_r <= brownout_sleep_disable_cnt_r - 3'd1;
					end
				end
				BS_DELAY: begin
					if (brownout_sleep_disable_cnt_r <= 3'd1) begin
						brownout_sleep_disable_st_r  <= BS_ACTIVE; // RULE23
						brownout_sleep_disable_r     <= 1'b1;
						brownout_sleep_disable_cnt_r <= BROWNOUT_SLEEP_DISABLE_HOLD_CYC;
					end else begin
						brownout_sleep_disable_cnt_r <= brownout_sleep_disable_cnt_r - 3'd1;
					end
				end
				BS_ACTIVE: begin
					if (brownout_sleep_disable_cnt_r <= 3'd1) begin
						brownout_sleep_disable_st_r <= BS_IDLE; // RULE23
						brownout_sleep_disable_r    <= 1'b0;
					end else begin
						brownout_sleep_disable_cnt_r <= brownout_sleep_disable_cnt_r - 3'd1;
					end
				end
				default: brownout_sleep_disable_st_r <= BS_IDLE;
			endcase
		end
	end
	assign brownout_sleep_disable_out = brownout_sleep_disable_r;
	assign reg_rdata_out              = rdata_r;

endmodule : srpg_top

// ==== core/srpg_pkg.sv ====
// srpg_pkg: constants and carriers for the reset and power gating block.
// assumes a single 250 MHz system clock and an 8-bit register port.
package srpg_pkg;

	// register map (byte offsets on the plain register port)
	localparam logic [7:0] PWR_GATES_OFS  = 8'h64;
	localparam logic [7:0] BOD_CTRL_OFS   = 8'h55;
	localparam logic [7:0] RST_STAT_OFS   = 8'h56;
	localparam logic [7:0] PWR_GATES_RST  = 8'h00;
	localparam logic [7:0] PWR_GATES_WMSK = 8'hef;

	// gating bit positions
	localparam int GATE_TWI_BIT   = 7;
	localparam int GATE_TIM2_BIT  = 6;
	localparam int GATE_TIM0_BIT  = 5;
	localparam int GATE_RSVD_BIT  = 4;
	localparam int GATE_TIM1_BIT  = 3;
	localparam int GATE_SPI_BIT   = 2;
	localparam int GATE_USART_BIT = 1;
	localparam int GATE_ADC_BIT   = 0;

	// brown-out sleep control bit positions
	localparam int BROWNOUT_SLEEP_DISABLE_BIT  = 6;
	localparam int BROWNOUT_SLEEP_WRITE_ENABLE_BIT = 5;

	// timed sequence figures, in system clock cycles
	localparam logic [2:0] BROWNOUT_SLEEP_WRITE_ENABLE_WINDOW_CYC = 3'd4;
	localparam logic [2:0] BROWNOUT_SLEEP_DISABLE_DELAY_CYC   = 3'd3;
	localparam logic [2:0] BROWNOUT_SLEEP_DISABLE_HOLD_CYC    = 3'd3;

	// clock and time figures
	localparam int CLK_MHZ          = 250;
	localparam int BOD_FILTER_NS    = 2000;
	localparam int BOD_FILTER_CYC   = (BOD_FILTER_NS * CLK_MHZ + 999) / 1000;
	localparam int RST_PULSE_MIN_NS = 2500;
	localparam int RST_PULSE_CYC    = (RST_PULSE_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam int TOUT_MS          = 65;
	localparam int TOUT_CYC         = TOUT_MS * CLK_MHZ * 1000;

	// analog, pin level and watchdog inputs
	typedef struct packed {
		logic por_ok;
		logic bod_low;
		logic ext_rst_n;
		logic wdt_rst;
	} srpg_src_t;

	// fuse settings
	typedef struct packed {
		logic       ext_rst_dis;
		logic [2:0] bod_level;
		logic [1:0] startup_time_select;
		logic [3:0] clock_source_select;
	} srpg_fuse_t;

	// peripheral side enables
	typedef struct packed {
		logic two_wire_serial_unit;
		logic tim2;
		logic tim0;
		logic tim1;
		logic spi;
		logic usart;
		logic adc;
	} srpg_clken_t;

	typedef enum logic [1:0] {
		RST_HOLD,
		RST_COUNT,
		RST_RUN
	} srpg_rst_t;

	typedef enum logic [1:0] {
		BS_IDLE,
		BS_ARMED,
		BS_DELAY,
		BS_ACTIVE
	} srpg_brownout_sleep_disable_t;

endpackage : srpg_pkg

// ==== verification/srpg_chk.sv ====
// srpg_chk: port properties of srpg_top.
// assumes one clock; bound to every srpg_top below.
`timescale 1ns/100ps
module srpg_chk
	import srpg_pkg::*;
(
	// watched ports
	input wire logic        mclk_in,
	input wire logic        rst_in,
	input wire logic [7:0]  reg_addr_in,
	input wire logic [7:0]  reg_wdata_in,
	input wire logic        reg_wr_in,
	input wire logic        reg_rd_in,
	input wire logic [7:0]  reg_rdata_out,
	input wire srpg_src_t   src_in,
	input wire srpg_fuse_t  fuse_in,
	input wire logic        comparator_bandgap_select_in,
	input wire logic        converter_enable_in,
	input wire srpg_clken_t clken_out,
	input wire logic        comparator_mux_allow_out,
	input wire logic        bandgap_enable_out,
	input wire logic        brownout_sleep_disable_out,
	input wire logic        sys_rst_out,
	input wire logic        port_rst_out
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (rst_in);
	wire brownout_sleep_disable_set = reg_wr_in && reg_addr_in == BOD_CTRL_OFS && reg_wdata_in[6:5] == 2'b10;
	wire gap_nxt  = fuse_in.bod_level != 3'h7 || comparator_bandgap_select_in || converter_enable_in;

	property p_por; !src_in.por_ok |=> sys_rst_out; endproperty
	a_por: assert property (p_por) else $error("no reset after supply low");
	property p_wdt; src_in.wdt_rst |=> sys_rst_out; endproperty
	a_wdt: assert property (p_wdt) else $error("no reset after watchdog pulse");
	property p_port; port_rst_out == sys_rst_out; endproperty
	a_port: assert property (p_port) else $error("port reset differs");
	// first edge after release still sees reset-time values
	property p_gap; !$past(rst_in) |-> bandgap_enable_out == $past(gap_nxt); endproperty
	a_gap: assert property (p_gap) else $error("bandgap enable wrong");
	property p_rsvd; reg_rd_in && reg_addr_in == PWR_GATES_OFS |=> !reg_rdata_out[4]; endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bit read one");
	property p_mux; !$past(rst_in) |-> comparator_mux_allow_out == clken_out.adc; endproperty
	a_mux: assert property (p_mux) else $error("mux allow differs from adc");
	property p_hold;
		$rose(brownout_sleep_disable_out) |->
			brownout_sleep_disable_out[*3] ##1 !brownout_sleep_disable_out;
	endproperty
	a_hold: assert property (p_hold) else $error("sleep disable length wrong");
	property p_set;
		$rose(brownout_sleep_disable_out) |-> $past(brownout_sleep_disable_set, 3) || $past(brownout_sleep_disable_set, 4);
	endproperty
	a_set: assert property (p_set) else $error("sleep disable without write");
	c_wdt: cover property (src_in.wdt_rst);
	c_brownout_sleep_disable: cover property ($rose(brownout_sleep_disable_out));
	c_run: cover property ($fell(sys_rst_out));
endmodule : srpg_chk

bind srpg_top srpg_chk u_chk (.mclk_in, .rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
	.reg_rd_in, .reg_rdata_out, .src_in, .fuse_in, .comparator_bandgap_select_in,
	.converter_enable_in, .clken_out, .comparator_mux_allow_out, .bandgap_enable_out,
	.brownout_sleep_disable_out, .sys_rst_out, .port_rst_out);

// ==== verification/srpg_far.sv ====
// srpg_far: supply detectors, reset pin and watchdog seen by the block.
// assumes the bench drives the request levels after rising edges.
`timescale 1ns/100ps
module srpg_far
	import srpg_pkg::*;
(
	// bench requests
	input  wire logic mclk_in,
	input  wire logic supply_ok_in,
	input  wire logic bod_dip_in,
	input  wire logic pin_low_in,
	input  wire logic wdt_req_in,
	// detector outputs
	output srpg_src_t src_out
);
	logic req_r;
	always_ff @(posedge mclk_in) req_r <= wdt_req_in;
	assign src_out.por_ok    = supply_ok_in;
	assign src_out.bod_low   = bod_dip_in;
	assign src_out.ext_rst_n = ~pin_low_in;
	// one-cycle pulse however long the request stands
	assign src_out.wdt_rst   = wdt_req_in & ~req_r;
endmodule : srpg_far

// ==== verification/srpg_top_test.sv ====
// srpg_top_test: directed register and reset source sequences.
// assumes srpg_far on the far side and srpg_chk bound to the top.
`timescale 1ns/100ps
module srpg_top_test
	import srpg_pkg::*;
;
	logic        mclk_in = 0, rst_in = 1, wr = 0, rd = 0, async = 0, cbg = 0, conv = 0;
	logic        ok = 1, dip = 0, pin = 0, wreq = 0, mux, gap, bsd, srst, prst;
	logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata;
	srpg_fuse_t  fuse = 10'h1e0;
	srpg_src_t   src;
	srpg_clken_t ck;
	int          fails = 0, num_checks = 0, n;
	int          ks[8] = '{0, 0, 0, 1, 1, 1, 2, 3};
	int          cs[8] = '{3, 8, 8, 3, 8, 8, 1, 1};
	logic [7:0]  es = 8'hd2, dis = 8'h04, bon = 8'h18;

	always #2 mclk_in = ~mclk_in;
	srpg_far FAR (.mclk_in, .supply_ok_in(ok), .bod_dip_in(dip), .pin_low_in(pin),
		.wdt_req_in(wreq), .src_out(src));
	srpg_top #(.TOUT_CYCLES(20), .FILT_CYCLES(4), .PULSE_CYCLES(4)) DUT (.mclk_in, .rst_in,
		.reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
		.reg_rdata_out(rdata), .src_in(src), .fuse_in(fuse), .timer_two_async_select_in(async),
		.comparator_bandgap_select_in(cbg), .converter_enable_in(conv), .clken_out(ck),
		.comparator_mux_allow_out(mux), .bandgap_enable_out(gap),
		.brownout_sleep_disable_out(bsd), .sys_rst_out(srst), .port_rst_out(prst));

	task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("mismatch %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk_in) {addr, wdata, wr} <= {a, d, 1'b1};
		@(posedge mclk_in) wr <= 1'b0;
	endtask : wr_reg
	task rd_reg(input logic [7:0] a, input logic [7:0] e);
		@(posedge mclk_in) {addr, rd} <= {a, 1'b1};
		@(posedge mclk_in) rd <= 1'b0;
		#1 chk("rdata", e, rdata);
	endtask : rd_reg
	task span();
		while (srst !== 1'b0 && n < 300) begin
			@(posedge mclk_in) #1 n++;
		end
	endtask : span
	// holds one source for c edges, then looks for a stretched reset
	task hit(input int k, input int c, input logic e);
		logic seen;
		seen = 0;
		@(posedge mclk_in) case (k) 0: pin <= 1; 1: dip <= 1; 2: ok <= 0; default: wreq <= 1; endcase
		repeat (c) @(posedge mclk_in);
		{pin, dip, ok, wreq} <= 4'h2;
		for (n = 0; n < 8; n++) @(posedge mclk_in) #1 seen |= srst;
		span();
		chk("rst_seen", {7'h0, e}, {7'h0, seen});
		if (e) chk("rst_span", 8'h01, {7'h0, n >= 20 && n <= 30});
	endtask : hit
	task brownout_sleep_disable(input logic [7:0] e);
		int h;
		h = 0;
		repeat (10) @(posedge mclk_in) #1 h += bsd;
		chk("brownout_sleep_disable", e, h[7:0]);
	endtask : brownout_sleep_disable
	task stop_test();
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : stop_test

	initial begin
		#100000 fails++;
		stop_test();
	end
	initial begin
		repeat (12) @(posedge mclk_in);
		rst_in <= 1'b0;
		n = 0;
		span();
		chk("rst_stretch", 8'h01, {7'h0, n >= 20 && n <= 30});
		rd_reg(PWR_GATES_OFS, PWR_GATES_RST);
		for (int i = 0; i < 8; i++) begin
			wr_reg(PWR_GATES_OFS, 8'h01 << i);
			rd_reg(PWR_GATES_OFS, (8'h01 << i) & PWR_GATES_WMSK);
		end
		wr_reg(PWR_GATES_OFS, 8'hff);
		repeat (3) @(posedge mclk_in);
		#1 chk("clken", 8'h00, {1'b0, ck, mux});
		@(posedge mclk_in) async <= 1'b1;
		repeat (3) @(posedge mclk_in);
		#1 chk("clken", 8'h40, {1'b0, ck, mux});
		hit(3, 1, 1'b1);
		rd_reg(PWR_GATES_OFS, 8'h00);
		wr_reg(8'h00, 8'hff);
		rd_reg(8'h00, 8'h00);
		for (int i = 0; i < 8; i++) begin
			fuse.ext_rst_dis <= dis[i];
			fuse.bod_level <= bon[i] ? 3'h0 : 3'h7;
			n = 0;
			hit(ks[i], cs[i], es[i]);
		end
		for (int i = 0; i < 8; i++) begin
			@(posedge mclk_in) {fuse.bod_level, cbg, conv} <= {i[0] ? 3'h0 : 3'h7, i[2:1]};
			repeat (2) @(posedge mclk_in);
			#1 chk("bandgap", {7'h0, i[2:0] != 0}, {7'h0, gap});
		end
		wr_reg(BOD_CTRL_OFS, 8'h60);
		wr_reg(BOD_CTRL_OFS, 8'h40);
		brownout_sleep_disable(8'h03);
		wr_reg(BOD_CTRL_OFS, 8'h40);
		brownout_sleep_disable(8'h00);
		wr_reg(BOD_CTRL_OFS, 8'h60);
		repeat (6) @(posedge mclk_in);
		wr_reg(BOD_CTRL_OFS, 8'h40);
		brownout_sleep_disable(8'h00);
		stop_test();
	end
endmodule : srpg_top_test
